// [rtl/sscd_map.svh]
// Register map, field positions, reset values and frame counts of the
// serial switch controller.
// Assumes inclusion by bare name from files under rtl/.
`ifndef SSCD_MAP_SVH
`define SSCD_MAP_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define SSCD_ADDR_SW_DATA 7'h01
`define SSCD_ADDR_ERR_CONFIG 7'h02
`define SSCD_ADDR_ERR_FLAGS 7'h03
`define SSCD_ADDR_BURST_EN 7'h05
`define SSCD_ADDR_SOFT_RESET 7'h0B

// ****************************************************************
// Flag clear frame: write of this data to this address
// ****************************************************************
`define SSCD_ADDR_CLEAR 7'h6C
`define SSCD_CLEAR_DATA 8'hA9

// ****************************************************************
// Error enable and flag bit positions
// ****************************************************************
`define SSCD_BIT_CRC 0
`define SSCD_BIT_SCLK 1
`define SSCD_BIT_ADDR 2

// ****************************************************************
// Reset values
// ****************************************************************
`define SSCD_ERR_CONFIG_RST 3'h6
`define SSCD_ERR_FLAGS_RST 3'h0
`define SSCD_BURST_RST 1'h0
`define SSCD_ALIGN_DEFAULT 8'h25

// ****************************************************************
// CRC and frame edge counts
// ****************************************************************
`define SSCD_CRC_POLY 8'h07
`define SSCD_CRC_SEED 8'h00
`define SSCD_EDGE_ADDR 6'h08
`define SSCD_EDGE_CHECK 6'h09
`define SSCD_EDGE_DATA 6'h10
`define SSCD_EDGE_CRC 6'h18
`define SSCD_COUNT_MAX 6'h3F

`endif

// [rtl/sscd_pkg.sv]
// Types shared by the serial switch controller.
// Assumes nothing of its surroundings.
package sscd_pkg;
  typedef enum logic {ST_IDLE, ST_FRAME} sscd_state_t;
  typedef logic [2:0] sscd_err_t;
  typedef logic [6:0] sscd_addr_t;
  typedef logic [7:0] sscd_byte_t;
  typedef logic [5:0] sscd_count_t;
endpackage

// [rtl/sscd_crc8.sv]
// Serial CRC-8 engine, most significant bit first.
// Assumes clear and shift_en come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "sscd_map.svh"

module sscd_crc8 #(
  parameter logic [7:0] POLY = `SSCD_CRC_POLY,
  parameter logic [7:0] SEED = `SSCD_CRC_SEED
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic clear,
  input wire logic shift_en,
  input wire logic data_bit,
  // Result
  output logic [7:0] crc
);
  logic [7:0] crc_q;
  logic [7:0] crc_d;
  logic feedback;

  always_comb begin
    feedback = crc_q[7] ^ data_bit;
    crc_d = crc_q;
    if (clear) begin
      crc_d = SEED;
    end else if (shift_en) begin
      crc_d = {crc_q[6:0], 1'b0} ^ (feedback ? POLY : 8'h00);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crc_q <= `SSCD_CRC_SEED;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
endmodule
`default_nettype wire

// [rtl/sscd_top.sv]
// Serial target interface of a four-switch controller, address mode only.
// Assumes cs_n, sclk and serial_in come from an outside host and are
// asynchronous to clk; the link clock must be well below half of clk.
//
// Notes on behaviour
// - Sample serial input on rising clock edges
// - Change serial output on falling edges, release at frame end
// - Output only pulls low or releases
// - Address mode from reset onward
// - Sixteen clocks per frame without CRC
// - Read/write bit, seven address, eight data
// - Address at edge eight, read data out
// - Write committed at sixteenth rising edge
// - Alignment byte on first eight falls
// - Three detectors, enables and flags
// - CRC adds eight clocks, 24 total
// - CRC covers the sixteen payload bits
// - Polynomial x8+x2+x+1, seed zero
// - Check CRC at edge 24, gate write
// - Reads append CRC byte after data
// - Reset enables clock count and address checks
// - Wrong clock count sets its flag
// - Short frames never write
// - Long frames still write at sixteen
// - Invalid address found at edge nine
// - Clear frame zeroes all flags
// - Reset opens switches, restores defaults
`timescale 1ns/10ps
`default_nettype none
`include "sscd_map.svh"

module sscd_top #(
  parameter int SW_COUNT = 4,
  parameter logic [7:0] ALIGN_PATTERN = `SSCD_ALIGN_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  // Open-drain serial output
  input wire logic serial_out_open_drain_i,
  output logic serial_out_open_drain_o,
  output logic serial_out_open_drain_oe_n,
  // Switch controls
  output logic [SW_COUNT-1:0] switch_en,
  // Status
  output sscd_pkg::sscd_err_t err_enable,
  output sscd_pkg::sscd_err_t err_flags,
  output logic burst_mode_en,
  output logic frame_active
);
  import sscd_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Bit 2 chip select, bit 1 serial clock, bit 0 serial data
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic cs_low;
  logic sdi_s;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_s1_q <= 3'h4;
      pin_s2_q <= 3'h4;
      pin_s3_q <= 2'h2;
    end else begin
      pin_s1_q <= {cs_n, sclk, serial_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q[2:1];
    end
  end

  // Edges found from the second stage against a third copy
  assign cs_low = !pin_s2_q[2];
  assign sdi_s = pin_s2_q[0];
  assign sclk_rise = pin_s2_q[1] && !pin_s3_q[0];
  assign sclk_fall = !pin_s2_q[1] && pin_s3_q[0];
  assign frame_start = cs_low && pin_s3_q[1];
  assign frame_end = !cs_low && !pin_s3_q[1];

  // ****************************************************************
  // Register file state
  // ****************************************************************
  logic [SW_COUNT-1:0] sw_q;
  logic [SW_COUNT-1:0] sw_d;
  sscd_err_t cfg_q;
  sscd_err_t cfg_d;
  sscd_err_t flags_q;
  sscd_err_t flags_d;
  logic burst_q;
  logic burst_d;

  // ****************************************************************
  // Frame state
  // ****************************************************************
  sscd_state_t state_q;
  sscd_state_t state_d;
  sscd_count_t count_q;
  sscd_count_t count_d;
  sscd_count_t count_inc;
  sscd_byte_t in_sr_q;
  sscd_byte_t in_sr_d;
  sscd_byte_t in_byte;
  logic rw_q;
  logic rw_d;
  sscd_addr_t addr_q;
  sscd_addr_t addr_d;
  sscd_byte_t rdata_q;
  sscd_byte_t rdata_d;
  sscd_byte_t wdata_q;
  sscd_byte_t wdata_d;
  logic inval_q;
  logic inval_d;
  logic crc_mode_q;
  logic crc_mode_d;
  logic out_q;
  logic out_d;

  // Commit and flag events from the frame logic
  logic wr_fire;
  sscd_byte_t wr_data;
  logic flags_clr;
  sscd_err_t flags_set;

  // ****************************************************************
  // CRC engine
  // ****************************************************************
  logic crc_shift;
  logic crc_bit;
  sscd_byte_t crc_val;

  // Read data bits enter the CRC as driven, all other bits as received
  assign crc_shift = (state_q == ST_FRAME) && !frame_end && sclk_rise
                     && (count_q < `SSCD_EDGE_DATA);
  assign crc_bit = (rw_q && (count_q >= `SSCD_EDGE_ADDR))
                   ? rdata_q[~count_q[2:0]] : sdi_s;

  sscd_crc8 #(
    .POLY(`SSCD_CRC_POLY),
    .SEED(`SSCD_CRC_SEED)
  ) u_crc (
    .clk(clk),
    .reset_n(reset_n),
    .clear(frame_start),
    .shift_en(crc_shift),
    .data_bit(crc_bit),
    .crc(crc_val)
  );

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic sscd_byte_t reg_read(input sscd_addr_t addr);
    sscd_byte_t value;
    value = 8'h00;
    unique case (addr)
      `SSCD_ADDR_SW_DATA: value = {{(8-SW_COUNT){1'b0}}, sw_q};
      `SSCD_ADDR_ERR_CONFIG: value = {5'h00, cfg_q};
      `SSCD_ADDR_ERR_FLAGS: value = {5'h00, flags_q};
      `SSCD_ADDR_BURST_EN: value = {7'h00, burst_q};
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  // Flag clear address is accepted for writes; data is judged later
  function automatic logic addr_invalid(input logic rw, input sscd_addr_t addr);
    logic known;
    known = (addr == `SSCD_ADDR_SW_DATA) || (addr == `SSCD_ADDR_ERR_CONFIG)
            || (addr == `SSCD_ADDR_ERR_FLAGS) || (addr == `SSCD_ADDR_BURST_EN)
            || (addr == `SSCD_ADDR_SOFT_RESET)
            || (!rw && (addr == `SSCD_ADDR_CLEAR));
    return !known || (!rw && (addr == `SSCD_ADDR_ERR_FLAGS));
  endfunction

  // Bit driven at falling edge n, where n rising edges are done
  function automatic logic drive_bit(input sscd_count_t n);
    sscd_count_t idx;
    logic bit_v;
    idx = n - 6'h01;
    bit_v = 1'b1;
    if ((n != 6'h00) && (n <= `SSCD_EDGE_ADDR)) begin
      bit_v = ALIGN_PATTERN[~idx[2:0]];
    end else if (rw_q && (n > `SSCD_EDGE_ADDR) && (n <= `SSCD_EDGE_DATA)) begin
      bit_v = rdata_q[~idx[2:0]];
    end else if (rw_q && crc_mode_q && (n > `SSCD_EDGE_DATA)
                 && (n <= `SSCD_EDGE_CRC)) begin
      bit_v = crc_val[~idx[2:0]];
    end
    return bit_v;
  endfunction

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  assign in_byte = {in_sr_q[6:0], sdi_s};
  assign count_inc = (count_q == `SSCD_COUNT_MAX) ? count_q : count_q + 6'h01;

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    in_sr_d = in_sr_q;
    rw_d = rw_q;
    addr_d = addr_q;
    rdata_d = rdata_q;
    wdata_d = wdata_q;
    inval_d = inval_q;
    crc_mode_d = crc_mode_q;
    out_d = out_q;
    wr_fire = 1'b0;
    wr_data = in_byte;
    flags_set = 3'h0;
    unique case (state_q)
      ST_IDLE: begin
        out_d = 1'b1;
        if (frame_start) begin
          state_d = ST_FRAME;
          count_d = 6'h00;
          inval_d = 1'b0;
          // Frame length is fixed by the enable seen at frame start
          crc_mode_d = cfg_q[`SSCD_BIT_CRC];
        end
      end
      ST_FRAME: begin
        if (frame_end) begin
          state_d = ST_IDLE;
          out_d = 1'b1;
          if (cfg_q[`SSCD_BIT_SCLK]
              && (count_q != (crc_mode_q ? `SSCD_EDGE_CRC : `SSCD_EDGE_DATA))) begin
            flags_set[`SSCD_BIT_SCLK] = 1'b1;
          end
        end else if (sclk_rise) begin
          count_d = count_inc;
          in_sr_d = in_byte;
          if (count_inc == `SSCD_EDGE_ADDR) begin
            rw_d = in_byte[7];
            addr_d = in_byte[6:0];
            rdata_d = reg_read(in_byte[6:0]);
          end
          if ((count_inc == `SSCD_EDGE_CHECK) && cfg_q[`SSCD_BIT_ADDR]
              && addr_invalid(rw_q, addr_q)) begin
            inval_d = 1'b1;
            flags_set[`SSCD_BIT_ADDR] = 1'b1;
          end
          if (count_inc == `SSCD_EDGE_DATA) begin
            wdata_d = in_byte;
            // Commit edge when CRC is off; short frames never reach it
            if (!crc_mode_q && !rw_q && !inval_q) begin
              wr_fire = 1'b1;
            end
          end
          if ((count_inc == `SSCD_EDGE_CRC) && crc_mode_q && !rw_q) begin
            wr_data = wdata_q;
            if (in_byte == crc_val) begin
              wr_fire = !inval_q;
            end else begin
              flags_set[`SSCD_BIT_CRC] = 1'b1;
            end
          end
        end else if (sclk_fall) begin
          out_d = drive_bit(count_q);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      count_q <= 6'h00;
      in_sr_q <= 8'h00;
      rw_q <= 1'b0;
      addr_q <= 7'h00;
      rdata_q <= 8'h00;
      wdata_q <= 8'h00;
      inval_q <= 1'b0;
      crc_mode_q <= 1'b0;
      out_q <= 1'b1;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      in_sr_q <= in_sr_d;
      rw_q <= rw_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      wdata_q <= wdata_d;
      inval_q <= inval_d;
      crc_mode_q <= crc_mode_d;
      out_q <= out_d;
    end
  end

  // ****************************************************************
  // Register writes and error flags
  // ****************************************************************
  assign flags_clr = wr_fire && (addr_q == `SSCD_ADDR_CLEAR)
                     && (wr_data == `SSCD_CLEAR_DATA);

  always_comb begin
    sw_d = sw_q;
    cfg_d = cfg_q;
    burst_d = burst_q;
    if (wr_fire) begin
      unique case (addr_q)
        `SSCD_ADDR_SW_DATA: sw_d = wr_data[SW_COUNT-1:0];
        `SSCD_ADDR_ERR_CONFIG: cfg_d = wr_data[2:0];
        `SSCD_ADDR_BURST_EN: burst_d = wr_data[0];
        default: sw_d = sw_q;
      endcase
    end
    // A flag raised in the clearing cycle survives the clear
    flags_d = (flags_q & ~{3{flags_clr}}) | flags_set;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sw_q <= '0;
      cfg_q <= `SSCD_ERR_CONFIG_RST;
      flags_q <= `SSCD_ERR_FLAGS_RST;
      burst_q <= `SSCD_BURST_RST;
    end else begin
      sw_q <= sw_d;
      cfg_q <= cfg_d;
      flags_q <= flags_d;
      burst_q <= burst_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Never drives high: released level comes from the outside pull-up
  assign serial_out_open_drain_o = 1'b0;
  assign serial_out_open_drain_oe_n = out_q;
  assign switch_en = sw_q;
  assign err_enable = cfg_q;
  assign err_flags = flags_q;
  assign burst_mode_en = burst_q;
  assign frame_active = (state_q == ST_FRAME);
endmodule
`default_nettype wire

// [testbench/sscd_checker.sv]
// Checker: timing relations at the switch controller ports.
// Assumes the link pins come from a host clocked by clk.
`timescale 1ns/10ps
`default_nettype none
module sscd_checker #(
  parameter int SW_COUNT = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out_open_drain_i,
  input wire logic serial_out_open_drain_o,
  input wire logic serial_out_open_drain_oe_n,
  // Status
  input wire logic [SW_COUNT-1:0] switch_en,
  input wire sscd_pkg::sscd_err_t err_enable,
  input wire sscd_pkg::sscd_err_t err_flags,
  input wire logic burst_mode_en,
  input wire logic frame_active
);
  import sscd_pkg::*;
  logic sclk_q, cs_q;
  logic [4:0] fl_q, rs_q, cr_q;
  // Raw pin edges; the windows allow for two to five clk of synchroniser lag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      fl_q <= 5'h00;
      rs_q <= 5'h00;
      cr_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      fl_q <= {fl_q[3:0], sclk_q & ~sclk};
      rs_q <= {rs_q[3:0], ~sclk_q & sclk};
      cr_q <= {cr_q[3:0], ~cs_q & cs_n};
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_OD_LOW: assert property (serial_out_open_drain_o == 1'b0)
    else $error("open-drain output drives high");
  AST_IDLE_REL: assert property (cs_n [*5] |-> serial_out_open_drain_oe_n)
    else $error("output pulled low outside a frame");
  AST_FALL_ONLY: assert property (!$stable(serial_out_open_drain_oe_n) |->
    (|fl_q[4:1] || |cr_q[4:1])) else $error("output changed away from a falling edge");
  AST_WR_AT_RISE: assert property (!$stable(switch_en) |-> |rs_q[4:1])
    else $error("switch register changed away from a rising edge");
  AST_CFG_AT_RISE: assert property (!$stable(err_enable) |-> |rs_q[4:1])
    else $error("error enables changed away from a rising edge");
  AST_CLR_AT_RISE: assert property (($past(err_flags) & ~err_flags) != 3'h0 |->
    |rs_q[4:1]) else $error("flags cleared away from a rising edge");
  AST_FLAG_EN: assert property ((err_flags & ~$past(err_flags) &
    ~(err_enable | $past(err_enable))) == 3'h0) else $error("disabled detector set a flag");
  AST_CNT_AT_CS: assert property ($rose(err_flags[1]) |-> |cr_q[4:1])
    else $error("clock count flag set away from frame end");
  AST_CHK_AT_RISE: assert property (($rose(err_flags[0]) || $rose(err_flags[2])) |->
    |rs_q[4:1]) else $error("address or crc flag set away from a rising edge");
  AST_ACTIVE: assert property (!cs_n [*5] |-> frame_active)
    else $error("frame not active under chip select");
  AST_RST: assert property ($rose(reset_n) |-> err_enable == 3'h6 &&
    err_flags == 3'h0 && switch_en == '0 && serial_out_open_drain_oe_n)
    else $error("wrong values after reset");
endmodule
bind sscd_top sscd_checker #(.SW_COUNT(SW_COUNT)) i_sscd_checker (.clk(clk),
  .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
  .serial_out_open_drain_i(serial_out_open_drain_i),
  .serial_out_open_drain_o(serial_out_open_drain_o),
  .serial_out_open_drain_oe_n(serial_out_open_drain_oe_n), .switch_en(switch_en),
  .err_enable(err_enable), .err_flags(err_flags), .burst_mode_en(burst_mode_en),
  .frame_active(frame_active));
`default_nettype wire

// [testbench/sscd_host.sv]
// Host model: mode 0 serial controller driving the link pins.
// Assumes clk is the bench clock and sdo the resolved wire level.
`timescale 1ns/10ps
`default_nettype none
module sscd_host (
  // Clock
  input wire logic clk,
  // Link pins
  input wire logic serial_out_open_drain,
  output var logic cs_n,
  output var logic sclk,
  output var logic serial_in,
  // Result of the last frame
  output var logic done,
  output var logic [23:0] rx
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
    done = 1'b0;
    rx = 24'h00_0000;
  end
  function automatic logic [7:0] crc8(input logic [15:0] p);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  // ****************************************************************
  // Frame: low phase 5 clk, high 3 clk, so 80 ns per serial clock
  // ****************************************************************
  // Samples late in the low phase, where the device has settled its bit
  task automatic frame(input logic [15:0] p, input int n, input logic bad);
    logic [23:0] b;
    b = {p, crc8(p) ^ {7'h00, bad}};
    rx <= 24'h00_0000;
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in <= b[23 - i];
      repeat (5) @(posedge clk);
      if (i > 0) rx <= {rx[22:0], serial_out_open_drain};
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    rx <= {rx[22:0], serial_out_open_drain};
    cs_n <= 1'b1;
    serial_in <= ~serial_in;
    repeat (6) @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench/sscd_top_tb.sv]
// Bench: host frames against the controller, results checked from a queue.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module sscd_top_tb;
  import sscd_pkg::*;
  logic clk, reset_n, serial_out_open_drain, done, cs_n, sclk, serial_in, od_o, od_oe_n, burst, active;
  logic [3:0] sw, d, nd;
  logic bm;
  sscd_err_t en, fl;
  logic [23:0] rx;
  logic [34:0] exp_q[$];
  int err_total, checks;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pull-up gives the high level whenever the device lets go
  assign serial_out_open_drain = od_oe_n ? 1'b1 : od_o;
  sscd_top #(.SW_COUNT(4)) i_sscd_top (.clk(clk), .reset_n(reset_n), .cs_n(cs_n),
    .sclk(sclk), .serial_in(serial_in), .serial_out_open_drain_i(serial_out_open_drain),
    .serial_out_open_drain_o(od_o), .serial_out_open_drain_oe_n(od_oe_n), .switch_en(sw),
    .err_enable(en), .err_flags(fl), .burst_mode_en(burst), .frame_active(active));
  sscd_host i_sscd_host (.clk(clk), .serial_out_open_drain(serial_out_open_drain), .cs_n(cs_n), .sclk(sclk),
    .serial_in(serial_in), .done(done), .rx(rx));
  task automatic end_of_test();
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************************************
  // Expected: switches, enables, flags and the bits seen on the wire
  // ****************************************************************
  task automatic go(input logic [15:0] p, input int n, input logic bad, input logic [3:0] s,
      input sscd_err_t e, input sscd_err_t f, input logic [7:0] rd);
    logic [23:0] r;
    r = (24'h00_0025 << (n - 8)) | ((24'h00_0001 << (n - 8)) - 24'h00_0001);
    if (p[15]) r = (n == 24) ? {8'h25, rd, i_sscd_host.crc8({p[15:8], rd})} : {8'h25, rd};
    exp_q.push_back({s, e, f, bm, r});
    i_sscd_host.frame(p, n, bad);
  endtask
  always @(posedge clk) begin
    if (done === 1'b1) begin
      checks++;
      if (exp_q.size() == 0 || exp_q[0] !== {sw, en, fl, burst, rx}) begin
        err_total++;
        $display("ERROR %0t exp %h got %h", $time, exp_q[0], {sw, en, fl, burst, rx});
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    err_total = 0;
    checks = 0;
    void'($urandom(32'hb11c));
    for (int k = 0; k < 2; k++) begin
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      d = 4'($urandom_range(15, 0));
      nd = ~d;
      // Burst enable is stored only; it must come back cleared after each reset
      bm = 1'b0;
      go(16'h8200, 16, 0, 4'h0, 3'h6, 3'h0, 8'h06);
      go({8'h01, 4'h0, d}, 16, 0, d, 3'h6, 3'h0, 8'h00);
      go(16'h8100, 16, 0, d, 3'h6, 3'h0, {4'h0, d});
      bm = 1'b1;
      go(16'h0501, 16, 0, d, 3'h6, 3'h0, 8'h00);
      go(16'h8500, 16, 0, d, 3'h6, 3'h0, 8'h01);
      go(16'h8B00, 16, 0, d, 3'h6, 3'h0, 8'h00);
      go({8'h01, 4'h0, nd}, 10, 0, d, 3'h6, 3'h2, 8'h00);
      go(16'h8300, 16, 0, d, 3'h6, 3'h2, 8'h02);
      go(16'h6CA9, 16, 0, d, 3'h6, 3'h0, 8'h00);
      go({8'h01, 4'h0, nd}, 18, 0, nd, 3'h6, 3'h2, 8'h00);
      go(16'h6CA9, 16, 0, nd, 3'h6, 3'h0, 8'h00);
      go(16'h7F5A, 16, 0, nd, 3'h6, 3'h4, 8'h00);
      go(16'h0307, 16, 0, nd, 3'h6, 3'h4, 8'h00);
      go(16'h6CA9, 16, 0, nd, 3'h6, 3'h0, 8'h00);
      go(16'h0202, 16, 0, nd, 3'h2, 3'h0, 8'h00);
      go(16'h7F5A, 16, 0, nd, 3'h2, 3'h0, 8'h00);
      go(16'h0207, 16, 0, nd, 3'h7, 3'h0, 8'h00);
      go({8'h01, 4'h0, d}, 24, 0, d, 3'h7, 3'h0, 8'h00);
      go(16'h8100, 24, 0, d, 3'h7, 3'h0, {4'h0, d});
      go({8'h01, 4'h0, nd}, 24, 1, d, 3'h7, 3'h1, 8'h00);
      go(16'h6CA9, 24, 0, d, 3'h7, 3'h0, 8'h00);
      go({8'h01, 4'h0, nd}, 16, 0, d, 3'h7, 3'h2, 8'h00);
      go(16'h6CA9, 24, 0, d, 3'h7, 3'h0, 8'h00);
    end
    @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
